// file: logic/lsas_map.vh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the light sensor readout. Assumes a 20 MHz reference clock.
 */
`ifndef LSAS_MAP_VH
`define LSAS_MAP_VH

// Register select offsets
`define LSAS_REG_CONTROL   4'h0
`define LSAS_REG_TIMING    4'h1
`define LSAS_REG_THLO_L    4'h2
`define LSAS_REG_THLO_H    4'h3
`define LSAS_REG_THHI_L    4'h4
`define LSAS_REG_THHI_H    4'h5
`define LSAS_REG_INTR      4'h6
`define LSAS_REG_ID        4'ha
`define LSAS_REG_BB_L      4'hc
`define LSAS_REG_BB_H      4'hd
`define LSAS_REG_IR_L      4'he
`define LSAS_REG_IR_H      4'hf

// Command byte fields
`define LSAS_CMD_SEL_BIT   7
`define LSAS_CMD_CLR_BIT   6
`define LSAS_CMD_WORD_BIT  5

// Timing register fields
`define LSAS_TIM_GAIN_BIT  4
`define LSAS_TIM_MAN_BIT   3

// Reset values and mode codes
`define LSAS_CTRL_RST      2'h0
`define LSAS_INTEGRATION_TIME_FIELD_RST     2'h2
`define LSAS_POWER_ON      2'h3
`define LSAS_INTEGRATION_TIME_FIELD_MANUAL  2'h3

// Slave addresses by select pin level
`define LSAS_ADDR_GND      7'h29
`define LSAS_ADDR_FLOAT    7'h39
`define LSAS_ADDR_VDD      7'h49

// Timing
`define LSAS_REF_HZ        20000000
`define LSAS_OSC_HZ        735000
`define LSAS_OSC_DIV       (`LSAS_REF_HZ / `LSAS_OSC_HZ)
`define LSAS_INTEGRATION_TIME_FIELD_BASE    918
`define LSAS_MULT_00       11
`define LSAS_MULT_01       81
`define LSAS_MULT_10       322
`define LSAS_COUNT_START   19'h00004
`define LSAS_FULL_SCALE    16'hffff
`define LSAS_LOW_GAIN_DIV  4'hf

`endif

// file: logic/lsas_top.v
/*
 * Two-channel light sensor readout: integrating counters for the
 * broadband and infrared channels and a Fast-mode I2C register slave.
 * Assumes the analog front end gives one pulse per charge quantum on
 * BB_PULSE/IR_PULSE and the pads resolve SDA from SDA_OUT/SDA_OE.
 */
`timescale 1ns/10ps
`default_nettype none
`include "lsas_map.vh"

// Function
// - Integration lasts 11, 81 or 322 times 918 oscillator cycles.
// - At most one count per two oscillator cycles, minus two counts.
// - Channel results saturate at 65535 and never wrap.
// - Low gain passes one of every sixteen pulses, both channels.
// - Both channels share one integration start and end.
// - At conversion end each count goes to its own data register.
// - Reads see whole bytes and consistent words, never half updates.
// - In timed modes the next integration starts by itself right after the transfer.
// - Access is over an I2C slave, clock at most 400 kHz.
// - Slave address follows the three-level select pin.
// - Written byte with top bit set is a command byte.
// - Low four command bits become the register pointer.
// - Reads return the register chosen by the pointer.
// - Plain writes and combined-format reads are both served.
// - Command bytes carry bit seven set.
// - Command bit six clears interrupts and never reads back.
// - Control 03h powers up, 00h down, reads back as written.
// - Manual bit starts/stops integration only when field is 11.
module lsas_top #(
    parameter OSC_DIV    = `LSAS_OSC_DIV,
    parameter INTEGRATION_TIME_FIELD_BASE = `LSAS_INTEGRATION_TIME_FIELD_BASE,
    parameter [7:0] ID_VALUE = 8'h5a  // Arbitrary identification value
) (
    // Clock and reset
    input  wire       REF_CLK,
    input  wire       RST_N,
    // Serial bus
    input  wire       SCL_IN,
    input  wire       SDA_IN,
    output reg        SDA_OUT,
    output reg        SDA_OE,
    // Address select pin comparators
    input  wire       ADDR_SEL_GND,
    input  wire       ADDR_SEL_VDD,
    // Analog front end
    input  wire       BB_PULSE,
    input  wire       IR_PULSE,
    output reg        GAIN_HIGH,
    output reg        POWERED,
    output reg        INTEGRATING,
    // Status
    output reg        CONV_DONE,
    output reg        INT_CLEAR
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_ACK  = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_RD   = 3'h4;
    localparam ST_RACK = 3'h5;

    // Pin synchronisers: bus pins and select pins
    reg  [2:0]  scl_sy_reg, sda_sy_reg, gnd_sy_reg, vdd_sy_reg;
    reg         scl_reg, sda_reg, gnd_reg, vdd_reg;
    reg         scl_d_reg, sda_d_reg;
    always @(posedge REF_CLK) begin
        scl_sy_reg <= {scl_sy_reg[1:0], SCL_IN};
        sda_sy_reg <= {sda_sy_reg[1:0], SDA_IN};
        gnd_sy_reg <= {gnd_sy_reg[1:0], ADDR_SEL_GND};
        vdd_sy_reg <= {vdd_sy_reg[1:0], ADDR_SEL_VDD};
        if (!RST_N) begin
            scl_reg   <= 1'b1;
            sda_reg   <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            gnd_reg   <= 1'b0;
            vdd_reg   <= 1'b0;
        end else begin
            if (scl_sy_reg[1] == scl_sy_reg[2]) scl_reg <= scl_sy_reg[2];
            if (sda_sy_reg[1] == sda_sy_reg[2]) sda_reg <= sda_sy_reg[2];
            if (gnd_sy_reg[1] == gnd_sy_reg[2]) gnd_reg <= gnd_sy_reg[2];
            if (vdd_sy_reg[1] == vdd_sy_reg[2]) vdd_reg <= vdd_sy_reg[2];
            scl_d_reg <= scl_reg;
            sda_d_reg <= sda_reg;
        end
    end

    wire scl_rise = scl_reg & ~scl_d_reg;
    wire scl_fall = ~scl_reg & scl_d_reg;
    wire start_c  = scl_reg & scl_d_reg & ~sda_reg & sda_d_reg;
    wire stop_c   = scl_reg & scl_d_reg & sda_reg & ~sda_d_reg;

    // Float when neither comparator trips
    wire [6:0] my_addr = gnd_reg ? `LSAS_ADDR_GND :
                         vdd_reg ? `LSAS_ADDR_VDD : `LSAS_ADDR_FLOAT;

    // Registers
    reg  [1:0]  ctrl_reg;
    reg         gain_reg, manual_reg;
    reg  [1:0]  integration_time_field_reg;
    reg  [7:0]  thlo_l_reg, thlo_h_reg, thhi_l_reg, thhi_h_reg, intr_reg;
    reg  [15:0] bb_data_reg, ir_data_reg;
    reg  [7:0]  hold_reg;
    reg  [1:0]  hold_vld_reg;

    // Oscillator tick from the reference clock
    reg  [7:0]  div_reg;
    wire        osc_tick = (div_reg == OSC_DIV[7:0] - 8'h01);
    always @(posedge REF_CLK) begin
        if (!RST_N || osc_tick) div_reg <= 8'h00;
        else div_reg <= div_reg + 8'h01;
    end

    // Integration sequencing shared by both channels
    reg  [18:0] icyc_reg;
    reg         man_d_reg;
    reg  [18:0] limit;
    // Products are 32 bits; 19 bits hold the longest period
    wire [31:0] lim0_full = INTEGRATION_TIME_FIELD_BASE * `LSAS_MULT_00;
    wire [31:0] lim1_full = INTEGRATION_TIME_FIELD_BASE * `LSAS_MULT_01;
    wire [31:0] lim2_full = INTEGRATION_TIME_FIELD_BASE * `LSAS_MULT_10;
    always @* begin
        case (integration_time_field_reg)
            2'h0: limit = lim0_full[18:0];
            2'h1: limit = lim1_full[18:0];
            2'h2: limit = lim2_full[18:0];
            default: limit = 19'h7ffff;
        endcase
    end
    wire powered  = (ctrl_reg == `LSAS_POWER_ON);
    wire manual_m = (integration_time_field_reg == `LSAS_INTEGRATION_TIME_FIELD_MANUAL);
    wire running  = powered && (!manual_m || manual_reg);
    // Shortening the field below the elapsed count ends it at the next tick
    wire auto_end = !manual_m && osc_tick && (icyc_reg >= limit - 19'h1);
    wire man_end  = manual_m && man_d_reg && !manual_reg;
    wire conv_end = powered && (auto_end || man_end);
    // Even ticks from four on: N / 2 - 2 slots, none on the end tick
    wire cnt_slot = running && osc_tick && !icyc_reg[0] &&
                    (icyc_reg >= `LSAS_COUNT_START);

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            icyc_reg  <= 19'h0;
            man_d_reg <= 1'b0;
        end else begin
            man_d_reg <= manual_reg;
            if (!running || conv_end) icyc_reg <= 19'h0;
            else if (osc_tick && icyc_reg != 19'h7ffff)
                icyc_reg <= icyc_reg + 19'h1;
        end
    end

    // Per-channel converter counters
    wire [1:0]  pulse_in = {IR_PULSE, BB_PULSE};
    wire [31:0] acc_all;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : conv
            reg [2:0]  sy_reg;
            reg        lvl_reg, lvl_d_reg, pend_reg;
            reg [3:0]  pre_reg;
            reg [15:0] acc_reg;
            wire       edge_w = lvl_reg & ~lvl_d_reg;
            // Low gain lets one pulse in sixteen through
            wire       pass = edge_w &&
                (gain_reg || pre_reg == `LSAS_LOW_GAIN_DIV);
            always @(posedge REF_CLK) begin
                sy_reg <= {sy_reg[1:0], pulse_in[g]};
                if (!RST_N) begin
                    lvl_reg   <= 1'b0;
                    lvl_d_reg <= 1'b0;
                    pend_reg  <= 1'b0;
                    pre_reg   <= 4'h0;
                    acc_reg   <= 16'h0;
                end else begin
                    if (sy_reg[1] == sy_reg[2]) lvl_reg <= sy_reg[2];
                    lvl_d_reg <= lvl_reg;
                    if (edge_w) pre_reg <= pre_reg + 4'h1;
                    // New pulse wins over consuming the old one
                    if (pass && running) pend_reg <= 1'b1;
                    else if (cnt_slot || !running) pend_reg <= 1'b0;
                    if (conv_end || !running) acc_reg <= 16'h0;
                    else if (cnt_slot && pend_reg &&
                             acc_reg != `LSAS_FULL_SCALE)
                        acc_reg <= acc_reg + 16'h1;
                end
            end
            assign acc_all[16*g +: 16] = acc_reg;
        end
    endgenerate

    // I2C slave
    reg  [2:0]  st_reg;
    reg  [3:0]  bit_reg;
    reg  [7:0]  sr_reg, tx_reg;
    reg         rw_reg, mack_reg;
    reg  [3:0]  ptr_reg;  // Kept across transactions
    reg         word_reg;
    reg         idx_reg;
    wire [3:0]  acc_addr = ptr_reg + {3'h0, word_reg & idx_reg};
    reg  [7:0]  rd_byte;
    always @* begin
        case (acc_addr)
            `LSAS_REG_CONTROL: rd_byte = {6'h0, ctrl_reg};
            `LSAS_REG_TIMING:  rd_byte = {3'h0, gain_reg, manual_reg,
                                          1'b0, integration_time_field_reg};
            `LSAS_REG_THLO_L:  rd_byte = thlo_l_reg;
            `LSAS_REG_THLO_H:  rd_byte = thlo_h_reg;
            `LSAS_REG_THHI_L:  rd_byte = thhi_l_reg;
            `LSAS_REG_THHI_H:  rd_byte = thhi_h_reg;
            `LSAS_REG_INTR:    rd_byte = intr_reg;
            `LSAS_REG_ID:      rd_byte = ID_VALUE;
            `LSAS_REG_BB_L:    rd_byte = bb_data_reg[7:0];
            `LSAS_REG_BB_H:    rd_byte = hold_vld_reg[0] ? hold_reg :
                                         bb_data_reg[15:8];
            `LSAS_REG_IR_L:    rd_byte = ir_data_reg[7:0];
            `LSAS_REG_IR_H:    rd_byte = hold_vld_reg[1] ? hold_reg :
                                         ir_data_reg[15:8];
            default:           rd_byte = 8'h00;
        endcase
    end

    wire wr_byte = (st_reg == ST_WR) && scl_fall && (bit_reg == 4'h8);
    wire is_cmd  = sr_reg[`LSAS_CMD_SEL_BIT];
    wire data_wr = wr_byte && !is_cmd;
    wire load_tx = scl_fall && ((st_reg == ST_ACK && rw_reg) ||
                                (st_reg == ST_RACK && mack_reg));

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_reg   <= ST_IDLE;
            bit_reg  <= 4'h0;
            sr_reg   <= 8'h00;
            tx_reg   <= 8'h00;
            rw_reg   <= 1'b0;
            mack_reg <= 1'b0;
            ptr_reg  <= 4'h0;
            word_reg <= 1'b0;
            idx_reg  <= 1'b0;
            SDA_OE   <= 1'b0;
            INT_CLEAR <= 1'b0;
        end else begin
            INT_CLEAR <= 1'b0;
            if (start_c) begin
                st_reg  <= ST_ADDR;
                bit_reg <= 4'h0;
                idx_reg <= 1'b0;
                SDA_OE  <= 1'b0;
            end else if (stop_c) begin
                st_reg <= ST_IDLE;
                SDA_OE <= 1'b0;
            end else begin
                case (st_reg)
                    ST_ADDR, ST_WR: begin
                        if (scl_rise) begin
                            sr_reg  <= {sr_reg[6:0], sda_reg};
                            bit_reg <= bit_reg + 4'h1;
                        end else if (scl_fall && bit_reg == 4'h8) begin
                            bit_reg <= 4'h0;
                            if (st_reg == ST_ADDR) begin
                                // Seven address bits then direction
                                if (sr_reg[7:1] == my_addr) begin
                                    rw_reg <= sr_reg[0];
                                    SDA_OE <= 1'b1;
                                    st_reg <= ST_ACK;
                                end else st_reg <= ST_IDLE;
                            end else begin
                                SDA_OE <= 1'b1;
                                st_reg <= ST_ACK;
                                if (is_cmd) begin
                                    ptr_reg  <= sr_reg[3:0];
                                    word_reg <= sr_reg[`LSAS_CMD_WORD_BIT];
                                    idx_reg  <= 1'b0;
                                    INT_CLEAR <= sr_reg[`LSAS_CMD_CLR_BIT];
                                end else idx_reg <= ~idx_reg;
                            end
                        end
                    end
                    ST_ACK: if (scl_fall) begin
                        bit_reg <= 4'h0;
                        if (rw_reg) begin
                            tx_reg <= rd_byte;
                            SDA_OE <= ~rd_byte[7];
                            st_reg <= ST_RD;
                        end else begin
                            SDA_OE <= 1'b0;
                            st_reg <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (scl_rise) bit_reg <= bit_reg + 4'h1;
                        else if (scl_fall) begin
                            if (bit_reg == 4'h8) begin
                                SDA_OE <= 1'b0;
                                idx_reg <= ~idx_reg;
                                st_reg <= ST_RACK;
                            end else begin
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                SDA_OE <= ~tx_reg[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) mack_reg <= ~sda_reg;
                        else if (scl_fall) begin
                            bit_reg <= 4'h0;
                            if (mack_reg) begin
                                tx_reg <= rd_byte;
                                SDA_OE <= ~rd_byte[7];
                                st_reg <= ST_RD;
                            end else st_reg <= ST_IDLE;
                        end
                    end
                    default: st_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Register writes, data transfer and word hold
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctrl_reg     <= `LSAS_CTRL_RST;
            gain_reg     <= 1'b0;
            manual_reg   <= 1'b0;
            integration_time_field_reg    <= `LSAS_INTEGRATION_TIME_FIELD_RST;
            thlo_l_reg   <= 8'h00;
            thlo_h_reg   <= 8'h00;
            thhi_l_reg   <= 8'h00;
            thhi_h_reg   <= 8'h00;
            intr_reg     <= 8'h00;
            bb_data_reg  <= 16'h0;
            ir_data_reg  <= 16'h0;
            hold_reg     <= 8'h00;
            hold_vld_reg <= 2'h0;
        end else begin
            if (data_wr) begin
                case (acc_addr)
                    `LSAS_REG_CONTROL: ctrl_reg <= sr_reg[1:0];
                    `LSAS_REG_TIMING: begin
                        gain_reg   <= sr_reg[`LSAS_TIM_GAIN_BIT];
                        manual_reg <= sr_reg[`LSAS_TIM_MAN_BIT];
                        integration_time_field_reg  <= sr_reg[1:0];
                    end
                    `LSAS_REG_THLO_L: thlo_l_reg <= sr_reg;
                    `LSAS_REG_THLO_H: thlo_h_reg <= sr_reg;
                    `LSAS_REG_THHI_L: thhi_l_reg <= sr_reg;
                    `LSAS_REG_THHI_H: thhi_h_reg <= sr_reg;
                    `LSAS_REG_INTR:   intr_reg   <= sr_reg;
                    default: ;
                endcase
            end
            if (conv_end) begin
                bb_data_reg <= acc_all[15:0];
                ir_data_reg <= acc_all[31:16];
            end
            // Low byte read freezes its high byte for the pair
            if (load_tx) begin
                hold_vld_reg <= 2'h0;
                if (acc_addr == `LSAS_REG_BB_L) begin
                    hold_reg     <= bb_data_reg[15:8];
                    hold_vld_reg <= 2'h1;
                end else if (acc_addr == `LSAS_REG_IR_L) begin
                    hold_reg     <= ir_data_reg[15:8];
                    hold_vld_reg <= 2'h2;
                end
            end else if (start_c && !(st_reg == ST_ACK || st_reg == ST_RD ||
                                      st_reg == ST_RACK))
                hold_vld_reg <= 2'h0;
        end
    end

    // Outputs
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            SDA_OUT     <= 1'b0;
            GAIN_HIGH   <= 1'b0;
            POWERED     <= 1'b0;
            INTEGRATING <= 1'b0;
            CONV_DONE   <= 1'b0;
        end else begin
            SDA_OUT     <= 1'b0;
            GAIN_HIGH   <= gain_reg;
            POWERED     <= powered;
            INTEGRATING <= running;
            CONV_DONE   <= conv_end;
        end
    end

endmodule // lsas_top
`default_nettype wire

// file: tb/lsas_i2c_master.sv
/* Bus master model: drives SCL and pulls SDA low.
   Assumes a pull-up on SDA outside and a free-running clk. */
`timescale 1ns/10ps
`default_nettype none
module lsas_i2c_master #(
    parameter int Q = 13  // Quarter bit: 13 clocks, 52 a bit, under 400 kHz
) (
    // Timing and bus
    input  wire logic clk,
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic step(input logic c, input logic d);
        scl = c;
        sda_low = d;
        repeat (Q) @(negedge clk);
    endtask
    // SDA only moves while SCL is low, except in START and STOP
    task automatic start;
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop;
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic bitx(input logic b, output logic r);
        step(1'b0, !b);
        step(1'b1, !b);
        r = sda;
        step(1'b1, !b);
        step(1'b0, !b);
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(v[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bitx(1'b1, r);
            v = {v[6:0], r};
        end
        bitx(last, r);  // Refusing the last byte ends the read
    endtask
endmodule // lsas_i2c_master
`default_nettype wire

// file: tb/lsas_top_asserts.sv
/* Port properties of lsas_top.
   Assumes binding to lsas_top by its port names. */
`timescale 1ns/10ps
`default_nettype none
module lsas_top_asserts (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Bus and status
    input wire logic SCL_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic GAIN_HIGH,
    input wire logic POWERED,
    input wire logic INTEGRATING,
    input wire logic CONV_DONE,
    input wire logic INT_CLEAR
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    chk_sda_open_drain:
        assert property (!SDA_OUT) else $error("SDA driven high");
    chk_oe_scl_low:
        assert property ($changed(SDA_OE) |-> !SCL_IN) else $error("SDA moved");
    chk_ack_held:
        assert property ($rose(SDA_OE) |=> SDA_OE [*8]) else $error("short pull");
    chk_power_scl_low:
        assert property ($changed(POWERED) |-> !SCL_IN) else $error("power");
    chk_gain_scl_low:
        assert property ($changed(GAIN_HIGH) |-> !SCL_IN) else $error("gain");
    chk_done_pulse:
        assert property (CONV_DONE |=> !CONV_DONE) else $error("done long");
    chk_done_integration_time_field:
        assert property (CONV_DONE |-> $past(INTEGRATING, 2)) else $error("done");
    chk_clear_pulse:
        assert property (INT_CLEAR |=> !INT_CLEAR) else $error("clear long");
    chk_off_idle:
        assert property (!POWERED [*2] |-> !INTEGRATING) else $error("off");
    chk_reset_quiet:
        assert property (disable iff (1'b0) !RST_N |=> !(SDA_OE | POWERED |
            INTEGRATING | CONV_DONE | INT_CLEAR)) else $error("reset");
    cover property (CONV_DONE);
    cover property (INT_CLEAR);
    cover property ($rose(SDA_OE));
endmodule // lsas_top_asserts
bind lsas_top lsas_top_asserts u_lsas_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .SCL_IN(SCL_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .GAIN_HIGH(GAIN_HIGH),
    .POWERED(POWERED), .INTEGRATING(INTEGRATING),
    .CONV_DONE(CONV_DONE), .INT_CLEAR(INT_CLEAR));
`default_nettype wire

// file: tb/light_sensor_adc_serial_slave_test.sv
/* Bench for lsas_top: bus master, register model, pulse stimulus.
   Assumes the master model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
    total_checks++; \
    if ((a) !== (e)) begin \
        mismatches++; \
        $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); \
    end \
end
module light_sensor_adc_serial_slave_test;
    localparam int DIV = 4;  // Short tick and base keep runs brief
    localparam int BASE = 4;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel_gnd = 1'b1;
    logic sel_vdd = 1'b0;
    logic bb = 1'b0;
    logic ir = 1'b0;
    logic bb_on = 1'b0;
    logic ir_on = 1'b0;
    logic [1:0] ph = 2'h0;
    logic a;
    logic wbit = 1'b0;
    logic [3:0] ptr = 4'h0;
    logic [6:0] adr = 7'h29;
    logic [15:0] w;
    logic [15:0] lfsr = 16'he75d;
    logic [7:0] d0;
    logic [7:0] d1;
    int mismatches = 0;
    int total_checks = 0;
    int clr_cnt = 0;
    int done_cnt = 0;
    int n;
    int mdl [16];
    wire logic scl;
    wire logic sda_low;
    wire logic sda_oe;
    wire logic gain;
    wire logic pwr;
    wire logic integration_time_field;
    wire logic done;
    wire logic clr;
    wire logic sda = !(sda_low || sda_oe === 1'b1);  // Pull-up
    lsas_top #(.OSC_DIV(DIV), .INTEGRATION_TIME_FIELD_BASE(BASE),
        .ID_VALUE(8'h3c)) uut (  // Arbitrary identification value
        .REF_CLK(ref_clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(), .SDA_OE(sda_oe), .ADDR_SEL_GND(sel_gnd),
        .ADDR_SEL_VDD(sel_vdd), .BB_PULSE(bb), .IR_PULSE(ir),
        .GAIN_HIGH(gain), .POWERED(pwr), .INTEGRATING(integration_time_field),
        .CONV_DONE(done), .INT_CLEAR(clr));
    lsas_i2c_master m (.clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    always #25 ref_clk = !ref_clk;
    always @(negedge ref_clk) begin
        // Two cycles high, two low: survives the pin filter
        ph <= ph + 2'h1;
        bb <= bb_on & ph[1];
        ir <= ir_on & ph[1];
    end
    // Off the launching edge, so each pulse counts once
    always @(negedge ref_clk) begin
        if (clr === 1'b1) clr_cnt++;
        if (done === 1'b1) done_cnt++;
    end
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0] & 8'h7f;  // Top bit clear keeps it data
    endfunction
    task automatic wr(input logic [7:0] cmd, d0, d1, input int nb);
        int t;
        m.start();
        m.wbyte({adr, 1'b0}, a);
        `CHK(a, 1'b1)
        m.wbyte(cmd, a);
        ptr = cmd[3:0];
        wbit = cmd[5];
        for (int i = 0; i < nb; i++) begin
            m.wbyte(i ? d1 : d0, a);
            t = ptr + (wbit ? i : 0);
            if (t < 7) mdl[t] = (i ? d1 : d0) & (t ? 8'hff : 8'h03);
        end
        m.stop();
    endtask
    task automatic rd(input logic [7:0] cmd, input int nb, input logic cmp);
        logic [7:0] v;
        if (cmd[7]) begin
            m.start();
            m.wbyte({adr, 1'b0}, a);
            m.wbyte(cmd, a);
            ptr = cmd[3:0];
            wbit = cmd[5];
        end
        m.start();
        m.wbyte({adr, 1'b1}, a);
        `CHK(a, 1'b1)
        for (int i = 0; i < nb; i++) begin
            m.rbyte(i == nb - 1, v);
            w = {v, w[15:8]};
            if (cmp) `CHK(v, mdl[ptr + (wbit ? i : 0)][7:0])
        end
        m.stop();
    endtask
    task automatic wait_done;
        n = 0;
        while (done !== 1'b1 && n < 30000) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(n < 30000, 1'b1)
        @(negedge ref_clk);
    endtask
    task automatic conv(input logic [1:0] f, input logic hi, input logic irx);
        int len;
        int full;
        bb_on = 1'b1;
        ir_on = irx;
        wr(8'h81, {3'h0, hi, 2'h0, f}, 8'h00, 1);
        `CHK(gain, hi)
        wait_done();
        wait_done();
        len = BASE * (f == 2'h0 ? 11 : f == 2'h1 ? 81 : 322);
        `CHK(n >= len * DIV - 2 && n <= len * DIV + 2, 1'b1)
        full = len / 2 - 2;
        if (full > 65535) full = 65535;
        mdl[12] = full % 256;
        mdl[13] = full / 256;
        mdl[14] = irx ? full % 256 : 0;
        mdl[15] = irx ? full / 256 : 0;
        rd(8'hac, 2, hi);
        if (!hi) `CHK(w >= 1 && w <= 7, 1'b1)
        rd(8'hae, 2, hi);
        if (!hi) `CHK(w >= 1 && w <= 7, 1'b1)
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        for (int k = 0; k < 16; k++) mdl[k] = 0;
        mdl[1] = 8'h02;
        mdl[10] = 8'h3c;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        `CHK({gain, pwr, integration_time_field}, 3'h0)
        rd(8'h81, 1, 1'b1);
        wr(8'h8a, 8'h11, 8'h00, 1);
        rd(8'h8a, 1, 1'b1);
        $display("end of reset and id test");
        for (int s = 0; s < 3; s++) begin
            sel_gnd = (s == 0);
            sel_vdd = (s == 2);
            adr = s == 0 ? 7'h29 : s == 1 ? 7'h39 : 7'h49;
            m.start();
            m.wbyte({adr ^ 7'h10, 1'b0}, a);
            m.stop();
            `CHK(a, 1'b0)
            wr(8'h80, s == 1 ? 8'h00 : 8'h03, 8'h00, 1);
            `CHK(pwr, s != 1)
            rd(8'h80, 1, 1'b1);
            rd(8'h00, 1, 1'b1);
        end
        $display("end of address and power test");
        d0 = rnd();
        d1 = rnd();
        wr(8'ha2, d0, d1, 2);
        rd(8'h82, 1, 1'b1);
        rd(8'h83, 1, 1'b1);
        n = clr_cnt;
        wr(8'hc6, 8'h00, 8'h00, 0);
        `CHK(clr_cnt - n, 1)
        rd(8'h00, 1, 1'b1);
        $display("end of word and clear test");
        conv(2'h0, 1'b1, 1'b0);
        conv(2'h1, 1'b1, 1'b1);
        conv(2'h2, 1'b1, 1'b0);
        conv(2'h0, 1'b0, 1'b1);
        $display("end of conversion test");
        wr(8'h81, 8'h1b, 8'h00, 1);
        `CHK(integration_time_field, 1'b1)
        n = done_cnt;
        wr(8'h81, 8'h13, 8'h00, 1);
        `CHK({integration_time_field, done_cnt > n}, 2'h1)
        wr(8'h80, 8'h00, 8'h00, 1);
        repeat (2) @(negedge ref_clk);
        `CHK({pwr, integration_time_field}, 2'h0)
        $display("end of manual and power down test");
        summarize();
    end
    // Whole run needs about 70000 clocks
    initial begin
        repeat (98000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end
endmodule // light_sensor_adc_serial_slave_test
`default_nettype wire
